/* shared/ptr_pkg.sv */
// package of the telemetry readback block: command codes, update selectors,
// scales, status bit positions and fsm states.
// assumes one 20 MHz clock shared with the command engine and measurement logic.
//
// Behaviour
// - code 0x89 answers input current, two bytes, same on every page
// - input current word is signed, value over 100 gives amperes
// - code 0x8b answers selected output voltage, signed word in volts
// - code 0x8c answers selected output current, signed two-byte word
// - output current word over 10 gives amperes, device encodes, host decodes
// - code 0x8d answers selected power stage temperature in degrees Celsius
// - code 0x8e answers global diode temperature on pin a when diode mode
// - code 0x8f answers global diode temperature on pin b when diode mode
// - code 0x96 answers selected output power, signed word in watts
// - code 0x97 answers paged input power, signed word in watts
// - code 0x98 answers one read-only revision byte, default 0x33
// - revision upper nibble is part 1, lower part 2, codes 0..3 mean 1.0..1.3
// - writing any of these commands sets communication fault bit 1 of status
package ptr_pkg;

  localparam int PTR_DATA_W = 16;
  localparam int PTR_PAGES = 2;

  localparam logic [7:0] PTR_CMD_IIN = 8'h89;
  localparam logic [7:0] PTR_CMD_VOUT = 8'h8b;
  localparam logic [7:0] PTR_CMD_IOUT = 8'h8c;
  localparam logic [7:0] PTR_CMD_TEMP_STAGE = 8'h8d;
  localparam logic [7:0] PTR_CMD_TEMP_A = 8'h8e;
  localparam logic [7:0] PTR_CMD_TEMP_B = 8'h8f;
  localparam logic [7:0] PTR_CMD_POUT = 8'h96;
  localparam logic [7:0] PTR_CMD_PIN = 8'h97;
  localparam logic [7:0] PTR_CMD_REVISION = 8'h98;

  // revision byte: part 1 in 7:4, part 2 in 3:0
  localparam logic [7:0] PTR_REVISION_RESET = 8'h33;
  localparam int PTR_REV_PART1_LSB = 4;
  localparam int PTR_REV_PART2_LSB = 0;

  // fixed-point scales of the current words (counts per ampere)
  localparam int PTR_IIN_SCALE = 100;
  localparam int PTR_IOUT_SCALE = 10;

  // communications status byte
  localparam int PTR_CML_WRITE_FAULT_BIT = 1;
  localparam logic [7:0] PTR_CML_RESET = 8'h00;
  localparam logic [15:0] PTR_READING_RESET = 16'h0000;
  localparam logic [15:0] PTR_NO_DIODE_VALUE = 16'h0000;

  // answer lengths in bytes
  localparam logic [1:0] PTR_LEN_NONE = 2'h0;
  localparam logic [1:0] PTR_LEN_BYTE = 2'h1;
  localparam logic [1:0] PTR_LEN_WORD = 2'h2;

  // selects which reading an update from the measurement logic refreshes
  typedef enum logic [3:0] {
    PTR_SEL_IIN = 4'h0,
    PTR_SEL_VOUT = 4'h1,
    PTR_SEL_IOUT = 4'h2,
    PTR_SEL_TEMP_STAGE = 4'h3,
    PTR_SEL_TEMP_A = 4'h4,
    PTR_SEL_TEMP_B = 4'h5,
    PTR_SEL_POUT = 4'h6,
    PTR_SEL_PIN = 4'h7,
    PTR_SEL_REVISION = 4'h8,
    PTR_SEL_NONE = 4'hf
  } ptr_sel_t;

  typedef enum logic [0:0] {
    PTR_ST_IDLE = 1'b0,
    PTR_ST_ANSWER = 1'b1
  } ptr_state_t;

endpackage

/* shared/ptr_page_if.sv */
// interface carrying the five paged readings of one output.
// assumes the bank drives it and the top only reads it.
`timescale 1ns/1ps
`default_nettype none
interface ptr_page_if;
  logic [15:0] vout;
  logic [15:0] iout;
  logic [15:0] temp_stage;
  logic [15:0] pout;
  logic [15:0] pin;
  modport bank (output vout, output iout, output temp_stage, output pout, output pin);
  modport reader (input vout, input iout, input temp_stage, input pout, input pin);
endinterface
`default_nettype wire

/* hdl/ptr_page_bank.sv */
// holding registers for the paged readings of one output.
// assumes updates come from measurement logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ptr_page_bank
  import ptr_pkg::*;
#(
  parameter logic [0:0] PAGE_ID = 1'b0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic upd_valid,
  input wire logic upd_page,
  input wire ptr_sel_t upd_sel,
  input wire logic [15:0] upd_value,
  ptr_page_if.bank readings
);

  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp_stage;
    logic [15:0] pout;
    logic [15:0] pin;
  } ptr_bank_state_t;

  ptr_bank_state_t state_q;
  ptr_bank_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (upd_valid && (upd_page == PAGE_ID)) begin
      case (upd_sel)
        PTR_SEL_VOUT: state_d.vout = upd_value;
        // already in tenths of an ampere from the measurement side
        PTR_SEL_IOUT: state_d.iout = upd_value;
        PTR_SEL_TEMP_STAGE: state_d.temp_stage = upd_value;
        PTR_SEL_POUT: state_d.pout = upd_value;
        PTR_SEL_PIN: state_d.pin = upd_value;
        default: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= '{PTR_READING_RESET, PTR_READING_RESET, PTR_READING_RESET,
                   PTR_READING_RESET, PTR_READING_RESET};
    end else if (clock_enable) begin
      state_q <= state_d;
    end
  end

  assign readings.vout = state_q.vout;
  assign readings.iout = state_q.iout;
  assign readings.temp_stage = state_q.temp_stage;
  assign readings.pout = state_q.pout;
  assign readings.pin = state_q.pin;

endmodule
`default_nettype wire

/* hdl/ptr_cmd_decode.sv */
// command code decoder: which reading, its length, paged or global.
// assumes a purely combinational use inside the top.
`timescale 1ns/1ps
`default_nettype none
module ptr_cmd_decode
  import ptr_pkg::*;
(
  input wire logic [7:0] code,
  output ptr_sel_t sel,
  output logic [1:0] len,
  output logic paged
);

  always_comb begin
    sel = PTR_SEL_NONE;
    len = PTR_LEN_NONE;
    paged = 1'b0;
    case (code)
      PTR_CMD_IIN: begin
        sel = PTR_SEL_IIN;
        len = PTR_LEN_WORD;
      end
      PTR_CMD_VOUT: begin
        sel = PTR_SEL_VOUT;
        len = PTR_LEN_WORD;
        paged = 1'b1;
      end
      PTR_CMD_IOUT: begin
        sel = PTR_SEL_IOUT;
        len = PTR_LEN_WORD;
        paged = 1'b1;
      end
      PTR_CMD_TEMP_STAGE: begin
        sel = PTR_SEL_TEMP_STAGE;
        len = PTR_LEN_WORD;
        paged = 1'b1;
      end
      PTR_CMD_TEMP_A: begin
        sel = PTR_SEL_TEMP_A;
        len = PTR_LEN_WORD;
      end
      PTR_CMD_TEMP_B: begin
        sel = PTR_SEL_TEMP_B;
        len = PTR_LEN_WORD;
      end
      PTR_CMD_POUT: begin
        sel = PTR_SEL_POUT;
        len = PTR_LEN_WORD;
        paged = 1'b1;
      end
      PTR_CMD_PIN: begin
        sel = PTR_SEL_PIN;
        len = PTR_LEN_WORD;
        paged = 1'b1;
      end
      PTR_CMD_REVISION: begin
        sel = PTR_SEL_REVISION;
        len = PTR_LEN_BYTE;
      end
      default: begin
        sel = PTR_SEL_NONE;
        len = PTR_LEN_NONE;
        paged = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

/* hdl/ptr_telemetry_top.sv */
// telemetry readback command set: answers read commands from the bus
// transaction engine with stored readings, flags writes to its known codes as faults.
// assumes the transaction engine, page setting and measurement logic
// all run on this clock; no pin is sampled here.
`timescale 1ns/1ps
`default_nettype none
module ptr_telemetry_top
  import ptr_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = PTR_REVISION_RESET
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic page_sel,
  input wire logic upd_valid,
  input wire logic upd_page,
  input wire logic [3:0] upd_sel,
  input wire logic [15:0] upd_value,
  input wire logic diode_mode_a,
  input wire logic diode_mode_b,
  input wire logic cml_clear,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [1:0] rsp_len,
  output logic rsp_write_fault,
  output logic rsp_unknown,
  output logic [7:0] cml_status,
  output logic write_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ptr_state_t state;
    logic [15:0] iin;
    logic [15:0] temp_a;
    logic [15:0] temp_b;
    logic [15:0] data;
    logic [1:0] len;
    logic wr_fault;
    logic unknown;
    logic [7:0] cml;
  } ptr_top_state_t;

  ptr_top_state_t state_q;
  ptr_top_state_t state_d;

  ptr_sel_t upd_sel_e;
  ptr_sel_t dec_sel;
  logic [1:0] dec_len;
  logic dec_paged;
  logic [15:0] page_word;
  logic [15:0] global_word;
  logic fault_event;

  assign upd_sel_e = ptr_sel_t'(upd_sel);

  ////////////////////////////////////////////////////////////////////////////
  // paged banks and decoder

  ptr_page_if page0_if ();
  ptr_page_if page1_if ();

  ptr_page_bank #(.PAGE_ID(1'b0)) u_bank0 (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .upd_valid(upd_valid),
    .upd_page(upd_page),
    .upd_sel(upd_sel_e),
    .upd_value(upd_value),
    .readings(page0_if)
  );

  ptr_page_bank #(.PAGE_ID(1'b1)) u_bank1 (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .upd_valid(upd_valid),
    .upd_page(upd_page),
    .upd_sel(upd_sel_e),
    .upd_value(upd_value),
    .readings(page1_if)
  );

  ptr_cmd_decode u_decode (
    .code(cmd_code),
    .sel(dec_sel),
    .len(dec_len),
    .paged(dec_paged)
  );

  ////////////////////////////////////////////////////////////////////////////
  // answer selection

  // paged words come from the bank of the current page
  always_comb begin
    page_word = PTR_READING_RESET;
    case (dec_sel)
      PTR_SEL_VOUT: page_word = page_sel ? page1_if.vout : page0_if.vout;
      PTR_SEL_IOUT: page_word = page_sel ? page1_if.iout : page0_if.iout;
      PTR_SEL_TEMP_STAGE: page_word = page_sel ? page1_if.temp_stage
                                               : page0_if.temp_stage;
      PTR_SEL_POUT: page_word = page_sel ? page1_if.pout : page0_if.pout;
      PTR_SEL_PIN: page_word = page_sel ? page1_if.pin : page0_if.pin;
      default: page_word = PTR_READING_RESET;
    endcase
  end

  // globals never look at page_sel
  always_comb begin
    global_word = PTR_READING_RESET;
    case (dec_sel)
      PTR_SEL_IIN: global_word = state_q.iin;
      // a pin not wired for a diode has no temperature to give
      PTR_SEL_TEMP_A: global_word = diode_mode_a ? state_q.temp_a
                                                 : PTR_NO_DIODE_VALUE;
      PTR_SEL_TEMP_B: global_word = diode_mode_b ? state_q.temp_b
                                                 : PTR_NO_DIODE_VALUE;
      // byte answer sits in the low lane, upper lane zero
      PTR_SEL_REVISION: global_word = {8'h00, REVISION_CODE[7:PTR_REV_PART1_LSB],
                                       REVISION_CODE[PTR_REV_PART1_LSB-1:PTR_REV_PART2_LSB]};
      default: global_word = PTR_READING_RESET;
    endcase
  end

  assign fault_event = cmd_valid && cmd_write && (dec_sel != PTR_SEL_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;

    // global readings refreshed by the measurement logic
    if (upd_valid) begin
      case (upd_sel_e)
        // already in hundredths of an ampere
        PTR_SEL_IIN: state_d.iin = upd_value;
        PTR_SEL_TEMP_A: state_d.temp_a = upd_value;
        PTR_SEL_TEMP_B: state_d.temp_b = upd_value;
        default: state_d.iin = state_q.iin;
      endcase
    end

    case (state_q.state)
      PTR_ST_IDLE: begin
        if (cmd_valid) begin
          state_d.state = PTR_ST_ANSWER;
          state_d.unknown = (dec_sel == PTR_SEL_NONE);
          state_d.wr_fault = fault_event;
          // a rejected write carries no data back
          state_d.len = cmd_write ? PTR_LEN_NONE : dec_len;
          state_d.data = cmd_write ? PTR_READING_RESET
                                   : (dec_paged ? page_word : global_word);
        end
      end
      PTR_ST_ANSWER: begin
        // one answer per command; a command arriving here is not taken
        state_d.state = PTR_ST_IDLE;
      end
      default: state_d.state = PTR_ST_IDLE;
    endcase

    // status bit: a new fault in the clearing cycle survives
    if (cml_clear) begin
      state_d.cml[PTR_CML_WRITE_FAULT_BIT] = 1'b0;
    end
    if (fault_event && (state_q.state == PTR_ST_IDLE)) begin
      state_d.cml[PTR_CML_WRITE_FAULT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= '{PTR_ST_IDLE, PTR_READING_RESET, PTR_READING_RESET, PTR_READING_RESET,
                   PTR_READING_RESET, PTR_LEN_NONE, 1'b0, 1'b0, PTR_CML_RESET};
    end else if (clock_enable) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rsp_valid = (state_q.state == PTR_ST_ANSWER);
  assign rsp_data = state_q.data;
  assign rsp_len = state_q.len;
  assign rsp_write_fault = state_q.wr_fault;
  assign rsp_unknown = state_q.unknown;
  assign cml_status = state_q.cml;
  assign write_fault = state_q.cml[PTR_CML_WRITE_FAULT_BIT];

endmodule
`default_nettype wire

/* sim/ptr_host_model.sv */
// host side model: issues telemetry read and write commands to the block.
// assumes callers enter its task just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module ptr_host_model
  import ptr_pkg::*;
(
  input wire logic clock,
  input wire logic rsp_valid,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic cmd_write,
  output logic page_sel
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_write = 1'b0;
    page_sel = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // idle cycles pace the host slow or back to back
  task automatic xfer(input logic [7:0] code, input logic wr, input logic pg,
      input int idle, output logic got);
    repeat (idle) @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_write = wr;
    page_sel = pg;
    @(negedge clock);
    got = rsp_valid;
    cmd_valid = 1'b0;
    // stale code scrambled so nothing leans on it after the request
    cmd_code = ~code;
    @(negedge clock);
  endtask
endmodule
`default_nettype wire

/* sim/ptr_telemetry_asserts.sv */
// checker of the telemetry readback top, bound to its ports.
// assumes one clock domain and the asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module ptr_telemetry_asserts
  import ptr_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = PTR_REVISION_RESET
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic page_sel,
  input wire logic upd_valid,
  input wire logic upd_page,
  input wire logic [3:0] upd_sel,
  input wire logic [15:0] upd_value,
  input wire logic diode_mode_a,
  input wire logic cml_clear,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [1:0] rsp_len,
  input wire logic rsp_write_fault,
  input wire logic rsp_unknown,
  input wire logic write_fault
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic taken;
  logic listed;
  assign taken = cmd_valid && clock_enable && !rsp_valid;
  assign listed = cmd_code inside {8'h89, [8'h8b:8'h8f], [8'h96:8'h98]};
  //////////////////////////////////////////////////////////////////////////////
  chk_read_word_len: assert property (taken && !cmd_write && listed && cmd_code != 8'h98
    |=> rsp_valid && rsp_len == PTR_LEN_WORD && !rsp_write_fault) else $error("word read bad");
  chk_revision_byte: assert property (taken && !cmd_write && cmd_code == 8'h98
    |=> rsp_valid && rsp_data == {8'h00, REVISION_CODE} && rsp_len == PTR_LEN_BYTE)
    else $error("revision byte bad");
  chk_write_refused: assert property (taken && cmd_write && listed
    |=> rsp_write_fault && rsp_len == PTR_LEN_NONE && write_fault) else $error("write not refused");
  chk_fault_sticky: assert property (write_fault && !cml_clear && clock_enable
    |=> write_fault) else $error("fault bit lost");
  chk_unknown_code: assert property (taken && !listed
    |=> rsp_unknown && !rsp_write_fault && rsp_len == PTR_LEN_NONE) else $error("unknown bad");
  chk_diode_off: assert property (taken && !cmd_write && cmd_code == 8'h8e && !diode_mode_a
    |=> rsp_data == 16'h0000) else $error("non diode pin read nonzero");
  chk_iin_update: assert property (clock_enable && upd_valid && upd_sel == 4'h0 ##1
    taken && cmd_code == 8'h89 && !cmd_write |=> rsp_data == $past(upd_value, 2))
    else $error("input current not fresh");
  chk_paged_follow: assert property (clock_enable && upd_valid && upd_sel == 4'h1 ##1
    taken && cmd_code == 8'h8b && !cmd_write && page_sel == $past(upd_page)
    |=> rsp_data == $past(upd_value, 2)) else $error("paged voltage not fresh");
  cover property (taken && cmd_write && listed);
  cover property (taken && cmd_code == 8'h98);
  cover property (taken && page_sel && !cmd_write);
  // a frozen edge must leave answer and status exactly as they were
  chk_freeze_hold: assert property (!clock_enable
    |=> $stable(rsp_valid) && $stable(rsp_data) && $stable(write_fault))
    else $error("clock enable low but state moved");
  cover property (cmd_valid && !clock_enable);
endmodule
bind ptr_telemetry_top ptr_telemetry_asserts #(.REVISION_CODE(REVISION_CODE))
  u_ptr_telemetry_asserts (.clock(clock), .reset(reset), .clock_enable(clock_enable),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write), .page_sel(page_sel),
  .upd_valid(upd_valid), .upd_page(upd_page), .upd_sel(upd_sel), .upd_value(upd_value),
  .diode_mode_a(diode_mode_a), .cml_clear(cml_clear), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_len(rsp_len), .rsp_write_fault(rsp_write_fault),
  .rsp_unknown(rsp_unknown), .write_fault(write_fault));
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the telemetry readback top with a host model.
// assumes a 20 MHz clock and inputs changed on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ptr_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cml_clear = 1'b0;
  logic clock_enable = 1'b1;
  logic upd_valid = 1'b0;
  logic upd_page = 1'b0;
  logic diode_mode_a = 1'b0;
  logic diode_mode_b = 1'b0;
  logic [3:0] upd_sel = 4'h0;
  logic [15:0] upd_value = 16'h0000;
  logic cmd_valid, cmd_write, page_sel, rsp_valid, rsp_write_fault, rsp_unknown, write_fault;
  logic [7:0] cmd_code, cml_status;
  logic [15:0] rsp_data;
  logic [1:0] rsp_len;
  int fails = 0;
  int n_compared = 0;
  always #25 clock = ~clock;
  ptr_telemetry_top u_ptr_telemetry_top (.clock(clock), .reset(reset), .clock_enable(clock_enable),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write), .page_sel(page_sel),
    .upd_valid(upd_valid), .upd_page(upd_page), .upd_sel(upd_sel), .upd_value(upd_value),
    .diode_mode_a(diode_mode_a), .diode_mode_b(diode_mode_b), .cml_clear(cml_clear),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_len(rsp_len),
    .rsp_write_fault(rsp_write_fault), .rsp_unknown(rsp_unknown), .cml_status(cml_status),
    .write_fault(write_fault));
  ptr_host_model u_ptr_host_model (.clock(clock), .rsp_valid(rsp_valid), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_write(cmd_write), .page_sel(page_sel));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] code, input logic pg, input int gap);
    logic v;
    u_ptr_host_model.xfer(code, 1'b0, pg, gap, v);
    chk({15'h0, v}, 16'h0001);
  endtask
  task automatic upd(input logic pg, input logic [3:0] sel, input logic [15:0] val);
    upd_valid = 1'b1;
    upd_page = pg;
    upd_sel = sel;
    upd_value = val;
    @(negedge clock);
    upd_valid = 1'b0;
  endtask
  task automatic t_paged;
    logic [7:0] codes [5];
    logic [3:0] sels [5];
    codes = '{8'h8b, 8'h8c, 8'h8d, 8'h96, 8'h97};
    sels = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        upd(p[0], sels[i], {4'h9, sels[i], 7'h00, p[0]});
        rd(codes[i], p[0], 0);
        chk(rsp_data, {4'h9, sels[i], 7'h00, p[0]});
      end
    end
    // second pass: page 1 must not leak into page 0 and back
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        rd(codes[i], p[0], 1);
        chk(rsp_data, {4'h9, sels[i], 7'h00, p[0]});
        chk({14'h0, rsp_len}, 16'h0002);
      end
    end
  endtask
  task automatic t_global;
    upd(1'b0, 4'h4, 16'hffd8);
    // one edge apart so the strobe is not lowered and raised in one step
    @(negedge clock);
    upd(1'b1, 4'h5, 16'h0055);
    rd(8'h8e, 1'b0, 0);
    chk(rsp_data, 16'h0000);
    rd(8'h8f, 1'b1, 0);
    chk(rsp_data, 16'h0000);
    diode_mode_a = 1'b1;
    diode_mode_b = 1'b1;
    // -12.3 A at ten counts per ampere
    upd(1'b1, 4'h2, 16'hff85);
    rd(8'h8c, 1'b1, 0);
    chk(rsp_data, 16'hff85);
    // 2.50 A at a hundred counts per ampere
    upd(1'b1, 4'h0, 16'h00fa);
    for (int p = 0; p < 2; p++) begin
      rd(8'h89, p[0], 0);
      chk(rsp_data, 16'h00fa);
      rd(8'h8e, p[0], 0);
      chk(rsp_data, 16'hffd8);
      rd(8'h8f, p[0], 0);
      chk(rsp_data, 16'h0055);
    end
  endtask
  task automatic t_rev;
    rd(8'h98, 1'b1, 0);
    chk(rsp_data, 16'h0033);
    chk({12'h000, rsp_data[7:4]}, 16'h0003);
    chk({14'h0, rsp_len}, 16'h0001);
  endtask
  task automatic t_writes;
    logic [7:0] codes [9];
    logic v;
    codes = '{8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'h96, 8'h97, 8'h98};
    for (int i = 0; i < 9; i++) begin
      u_ptr_host_model.xfer(codes[i], 1'b1, 1'b0, 0, v);
      chk({11'h0, v, rsp_write_fault, rsp_len, rsp_unknown}, 16'h0018);
      chk({8'h00, cml_status}, 16'h0002);
      cml_clear = 1'b1;
      @(negedge clock);
      cml_clear = 1'b0;
      chk({15'h0, write_fault}, 16'h0000);
    end
    u_ptr_host_model.xfer(8'h88, 1'b1, 1'b0, 0, v);
    chk({11'h0, v, rsp_write_fault, rsp_len, rsp_unknown}, 16'h0011);
    chk({8'h00, cml_status}, 16'h0000);
    // clear and fault on one edge: the fault must win
    cml_clear = 1'b1;
    fork
      u_ptr_host_model.xfer(8'h97, 1'b1, 1'b1, 0, v);
      begin
        @(negedge clock);
        cml_clear = 1'b0;
      end
    join
    chk({8'h00, cml_status}, 16'h0002);
  endtask
  // enable low: neither update nor command may land; then an unknown read
  task automatic t_freeze;
    logic v;
    clock_enable = 1'b0;
    upd(1'b0, 4'h1, 16'h1234);
    u_ptr_host_model.xfer(8'h8b, 1'b1, 1'b0, 0, v);
    chk({15'h0, v}, 16'h0000);
    chk({8'h00, cml_status}, 16'h0000);
    clock_enable = 1'b1;
    rd(8'h8b, 1'b0, 0);
    chk(rsp_data, 16'h9100);
    rd(8'h88, 1'b0, 0);
    chk({12'h000, rsp_write_fault, rsp_len, rsp_unknown}, 16'h0001);
    chk(rsp_data, 16'h0000);
  endtask
  // mid-run reset wipes status and readings
  task automatic t_reset;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    chk({8'h00, cml_status}, 16'h0000);
    rd(8'h8b, 1'b1, 0);
    chk(rsp_data, 16'h0000);
    rd(8'h89, 1'b0, 0);
    chk(rsp_data, 16'h0000);
  endtask
  task automatic give_verdict;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    chk({8'h00, cml_status}, 16'h0000);
    t_paged();
    t_freeze();
    t_global();
    t_rev();
    t_writes();
    t_reset();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
